// [rtl/csep_servo_encoder.sv]
// Purpose: quadrature position counter and servo pwm generator
// Assumes: encoder inputs synchronous to mclk, one edge per cycle at most
// Notes: a step where both channels change is treated as no count
`timescale 1ns/1ps
module csep_servo_encoder
  import csep_pkg::*;
#(
  parameter int unsigned POS_W = CSEP_POS_W,
  parameter int unsigned PWM_W = CSEP_PWM_W
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // encoder detectors
  input wire csep_quad_s enc_in,
  // processor side
  input wire logic duty_wr,
  input wire logic [PWM_W-1:0] duty_data,
  output logic [POS_W-1:0] pos_count,
  output logic [PWM_W-1:0] duty_value,
  // motor driver
  output logic motor_pwm
);

  // decode one step from previous and present channel levels
  function automatic csep_step_e quad_step(input csep_quad_s prv, input csep_quad_s cur);
    csep_step_e s;
    s = CSEP_STEP_NONE;
    if (prv.a != cur.a && prv.b == cur.b)
      s = ((cur.a ^ cur.b) != 1'b0) ? CSEP_STEP_LEFT : CSEP_STEP_RIGHT;
    else if (prv.b != cur.b && prv.a == cur.a)
      s = ((cur.a ^ cur.b) != 1'b0) ? CSEP_STEP_RIGHT : CSEP_STEP_LEFT;
    return s;
  endfunction : quad_step

  csep_quad_s enc_prev_ff;
  csep_quad_s nxt_enc_prev;
  logic [POS_W-1:0] pos_ff;
  logic [POS_W-1:0] nxt_pos;
  logic primed_ff;
  logic nxt_primed;
  csep_step_e step;

  always_comb
  begin
    nxt_enc_prev = enc_in;
    nxt_primed = 1'b1;
    step = primed_ff ? quad_step(enc_prev_ff, enc_in) : CSEP_STEP_NONE;
    nxt_pos = pos_ff;
    unique case (step)
      CSEP_STEP_LEFT: nxt_pos = pos_ff + 1'b1;
      CSEP_STEP_RIGHT: nxt_pos = pos_ff - 1'b1;
      CSEP_STEP_NONE: nxt_pos = pos_ff;
      default: nxt_pos = pos_ff;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      enc_prev_ff <= '0;
      pos_ff <= POS_W'(CSEP_POS_RST);
      primed_ff <= 1'b0;
    end
    else
    begin
      enc_prev_ff <= nxt_enc_prev;
      pos_ff <= nxt_pos;
      primed_ff <= nxt_primed;
    end
  end

  assign pos_count = pos_ff;

  // pwm: duty register and free-running period counter
  logic [PWM_W-1:0] duty_ff;
  logic [PWM_W-1:0] nxt_duty;
  logic [PWM_W-1:0] cnt_ff;
  logic [PWM_W-1:0] nxt_cnt;
  logic pwm_ff;
  logic nxt_pwm;

  always_comb
  begin
    nxt_duty = duty_wr ? duty_data : duty_ff;
    nxt_cnt = cnt_ff + 1'b1;
    nxt_pwm = (nxt_cnt < duty_ff);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      duty_ff <= PWM_W'(CSEP_DUTY_RST);
      cnt_ff <= '0;
      pwm_ff <= 1'b0;
    end
    else
    begin
      duty_ff <= nxt_duty;
      cnt_ff <= nxt_cnt;
      pwm_ff <= nxt_pwm;
    end
  end

  assign duty_value = duty_ff;
  assign motor_pwm = pwm_ff;

  a_left_count_up: assert property (@(posedge mclk) disable iff (rst)
    (primed_ff && enc_prev_ff.a != enc_in.a && enc_prev_ff.b == enc_in.b && (enc_in.a ^ enc_in.b))
    |=> pos_count == $past(pos_count) + 1'b1)
    else $error("left step did not increment");
  a_right_count_dn: assert property (@(posedge mclk) disable iff (rst)
    (primed_ff && enc_prev_ff.b != enc_in.b && enc_prev_ff.a == enc_in.a && (enc_in.a ^ enc_in.b))
    |=> pos_count == $past(pos_count) - 1'b1)
    else $error("right step did not decrement");
  a_count_hold_idle: assert property (@(posedge mclk) disable iff (rst)
    (enc_prev_ff == enc_in) |=> $stable(pos_count))
    else $error("counter moved without encoder edge");
  a_count_wrap_up: assert property (@(posedge mclk) disable iff (rst)
    (pos_count == 8'hFF && step == CSEP_STEP_LEFT) |=> pos_count == 8'h00)
    else $error("counter did not wrap");
  a_duty_write_load: assert property (@(posedge mclk) disable iff (rst)
    duty_wr |=> duty_value == $past(duty_data))
    else $error("duty write lost");
  a_pwm_zero_off: assert property (@(posedge mclk) disable iff (rst)
    (duty_value == 8'h00 && !duty_wr) [*2] |-> !motor_pwm)
    else $error("pwm on with zero duty");
  a_pwm_high_seen: assert property (@(posedge mclk) disable iff (rst)
    (duty_value == 8'h80 && !duty_wr) [*3] |-> ##[0:260] motor_pwm)
    else $error("pwm never high");
  a_pwm_low_seen: assert property (@(posedge mclk) disable iff (rst)
    (duty_value == 8'h80 && !duty_wr) [*3] |-> ##[0:260] !motor_pwm)
    else $error("pwm never low");

  // step checks for the left b-edge and right a-edge, for refused steps, then wrap-down, duty hold and pwm checks
  a_left_b_edge: assert property (@(posedge mclk) disable iff (rst)
    (primed_ff && enc_prev_ff.b != enc_in.b && enc_prev_ff.a == enc_in.a && !(enc_in.a ^ enc_in.b))
    |=> pos_count == $past(pos_count) + 1'b1)
    else $error("left b-edge did not increment");

  a_right_a_edge: assert property (@(posedge mclk) disable iff (rst)
    (primed_ff && enc_prev_ff.a != enc_in.a && enc_prev_ff.b == enc_in.b && !(enc_in.a ^ enc_in.b))
    |=> pos_count == $past(pos_count) - 1'b1)
    else $error("right a-edge did not decrement");

  a_both_edge_none: assert property (@(posedge mclk) disable iff (rst)
    (primed_ff && enc_prev_ff.a != enc_in.a && enc_prev_ff.b != enc_in.b)
    |=> $stable(pos_count))
    else $error("double edge changed counter");

  a_unprimed_hold: assert property (@(posedge mclk) disable iff (rst)
    !primed_ff
    |=> $stable(pos_count))
    else $error("counter moved on reference sample");

  a_count_wrap_dn: assert property (@(posedge mclk) disable iff (rst)
    (pos_count == 8'h00 && step == CSEP_STEP_RIGHT)
    |=> pos_count == 8'hFF)
    else $error("counter did not wrap down");

  a_duty_hold_idle: assert property (@(posedge mclk) disable iff (rst)
    !duty_wr
    |=> $stable(duty_value))
    else $error("duty changed without write");

  a_pwm_full_low: assert property (@(posedge mclk) disable iff (rst)
    (duty_value == 8'hFF && !duty_wr && cnt_ff == 8'hFE)
    |=> !motor_pwm)
    else $error("pwm high at period end with full duty");

  a_pwm_reset_low: assert property (@(posedge mclk) disable iff (rst)
    $past(rst)
    |-> !motor_pwm)
    else $error("pwm high after reset");

  // assertion helpers: cycles since last duty write, pwm levels seen since
  localparam int unsigned WATCH_LIM = 300;
  logic [8:0] watch_ff;
  logic [8:0] nxt_watch;
  logic seen_hi_ff;
  logic nxt_seen_hi;
  logic seen_lo_ff;
  logic nxt_seen_lo;

  always_comb
  begin
    nxt_watch = watch_ff;
    nxt_seen_hi = seen_hi_ff | motor_pwm;
    nxt_seen_lo = seen_lo_ff | !motor_pwm;
    if (duty_wr)
    begin
      nxt_watch = '0;
      nxt_seen_hi = 1'b0;
      nxt_seen_lo = 1'b0;
    end
    else if (watch_ff != 9'(WATCH_LIM))
      nxt_watch = watch_ff + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      watch_ff <= '0;
      seen_hi_ff <= 1'b0;
      seen_lo_ff <= 1'b0;
    end
    else
    begin
      watch_ff <= nxt_watch;
      seen_hi_ff <= nxt_seen_hi;
      seen_lo_ff <= nxt_seen_lo;
    end
  end

  a_pwm_high_due: assert property (@(posedge mclk) disable iff (rst)
    (watch_ff == 9'(WATCH_LIM) && duty_value != 8'h00)
    |-> seen_hi_ff)
    else $error("pwm not high within a period");

  a_pwm_low_due: assert property (@(posedge mclk) disable iff (rst)
    (watch_ff == 9'(WATCH_LIM))
    |-> seen_lo_ff)
    else $error("pwm not low within a period");

endmodule : csep_servo_encoder

// [shared/csep_pkg.sv]
// Purpose: constants and types for the carriage encoder counter and servo pwm
// Assumes: encoder channels already synchronous to mclk
// Notes: no software registers; counter and duty value are plain ports
package csep_pkg;
  localparam int unsigned CSEP_POS_W = 8;
  localparam int unsigned CSEP_PWM_W = 8;
  localparam logic [7:0] CSEP_POS_RST = 8'h00;
  localparam logic [7:0] CSEP_DUTY_RST = 8'h00;
  localparam int unsigned CSEP_LINES_PER_INCH = 150;
  localparam int unsigned CSEP_COUNTS_PER_LINE = 4;
  localparam int unsigned CSEP_COUNTS_PER_INCH = CSEP_LINES_PER_INCH * CSEP_COUNTS_PER_LINE;

  typedef struct packed {
    logic a;
    logic b;
  } csep_quad_s;

  typedef enum logic [1:0] {
    CSEP_STEP_NONE,
    CSEP_STEP_LEFT,
    CSEP_STEP_RIGHT
  } csep_step_e;
endpackage : csep_pkg

// [test/csep_enc_model.sv]
// Purpose: quadrature detector model for the carriage strip
// Assumes: at most one step request per cycle
// Notes: left walks 00,10,11,01; one channel moves per step
`timescale 1ns/1ps
module csep_enc_model
  import csep_pkg::*;
(
  // clock
  input wire logic mclk,
  // step requests
  input wire logic go_left,
  input wire logic go_right,
  // detectors
  output csep_quad_s enc
);
  logic [1:0] ph_ff = 2'h0;
  always_ff @(posedge mclk)
  begin
    if (go_left)
      ph_ff <= ph_ff + 2'h1;
    else if (go_right)
      ph_ff <= ph_ff - 2'h1;
  end
  // quarter-line offset between the two detectors
  assign enc.a = ph_ff[1] ^ ph_ff[0];
  assign enc.b = ph_ff[1];
endmodule : csep_enc_model

// [test/tb_top.sv]
// Purpose: self-checking bench for the encoder counter and pwm
// Assumes: bench acts as the processor
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module tb_top;
  import csep_pkg::*;
  logic mclk = 0, rst = 1, go_left = 0, go_right = 0, duty_wr = 0, motor_pwm;
  logic [7:0] duty_data = 8'h00, pos_count, duty_value;
  csep_quad_s enc;
  int bad_count = 0, checked = 0;
  always #10 mclk = ~mclk;
  csep_enc_model enc_u (.mclk(mclk), .go_left(go_left), .go_right(go_right), .enc(enc));
  csep_servo_encoder dut_u (.mclk(mclk), .rst(rst), .enc_in(enc), .duty_wr(duty_wr), .duty_data(duty_data),
    .pos_count(pos_count), .duty_value(duty_value), .motor_pwm(motor_pwm));
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic summarize;
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic t_move(input logic lt, input int n, input logic [7:0] e);
    repeat (n)
    begin
      go_left = lt;
      go_right = !lt;
      tick;
    end
    go_left = 0;
    go_right = 0;
    repeat (3) tick;
    chk(e, pos_count);
  endtask : t_move
  task automatic t_pwm(input logic [7:0] d);
    logic [7:0] hi;
    duty_wr = 1;
    duty_data = d;
    tick;
    duty_wr = 0;
    tick;
    chk(d, duty_value);
    hi = 8'h00;
    repeat (3) tick;
    repeat (256)
    begin
      hi = hi + {7'h00, motor_pwm};
      tick;
    end
    chk(d, hi);
  endtask : t_pwm
  // one scaled servo interrupt: read counter, fold signed difference, rewrite duty
  task automatic t_irq(inout logic [7:0] prev, inout int abs_pos, input logic [7:0] d);
    logic [7:0] now;
    now = pos_count;
    abs_pos = abs_pos + int'($signed(now - prev));
    prev = now;
    duty_wr = 1;
    duty_data = d;
    tick;
    duty_wr = 0;
    chk(d, duty_value);
  endtask : t_irq
  task automatic t_servo;
    logic [7:0] prev;
    int abs_pos;
    abs_pos = 0;
    prev = pos_count;
    t_move(1, 100, 8'h62);
    t_irq(prev, abs_pos, 8'h20);
    t_move(0, 120, 8'hEA);
    t_irq(prev, abs_pos, 8'h10);
    chk(8'hEC, abs_pos[7:0]);
  endtask : t_servo
  initial
  begin
    repeat (3) @(posedge mclk);
    #1;
    rst = 0;
    tick;
    chk(8'h00, pos_count);
    chk(8'h00, {7'h00, motor_pwm});
    t_move(1, 4, 8'h04);
    t_move(0, 6, 8'hFE);
    t_move(1, 256, 8'hFE);
    t_servo;
    t_pwm(8'h40);
    t_pwm(8'h00);
    t_pwm(8'h80);
    t_pwm(8'hFF);
    summarize;
  end
  initial
  begin
    #100000;
    bad_count++;
    summarize;
  end
endmodule : tb_top
